// *** design/ccw_bus_seq.sv ***
// bus cycle sequencer: snoop writebacks, posted writes, i/o writes and reads
`timescale 1ns/10ps
module ccw_bus_seq (
	input wire logic i_clk,
	input wire logic i_rst_n,
	ccw_link_if.seq lk,
	input wire logic i_wb_req,
	input wire logic [31:0] i_wb_addr,
	input wire logic i_io_req,
	input wire logic [31:0] i_io_addr,
	input wire logic [63:0] i_io_data,
	input wire logic i_rd_req,
	input wire logic [31:0] i_rd_addr,
	input wire logic i_rd_cacheable,
	input wire logic i_rd_pwt,
	input wire logic i_rd_io,
	input wire logic i_burst_ready_n,
	input wire logic i_next_address_req_n,
	input wire logic i_write_policy_select,
	input wire logic i_cache_enable_in_n,
	input wire logic i_bus_backoff_n,
	output logic o_bus_req,
	output logic [31:0] o_bus_addr,
	output logic [63:0] o_bus_data,
	output logic o_bus_write,
	output logic o_bus_io,
	output logic o_bus_pwt,
	output logic o_done,
	output ccw_pkg::ccw_cyc_type o_done_kind,
	output logic o_done_wp,
	output logic o_done_fill
);
	import ccw_pkg::*;

	ccw_seq_type state_reg;
	ccw_cyc_type kind_reg;
	logic first_reg;
	logic wp_reg;
	logic ken_n_reg;
	logic backed_reg;
	logic [1:0] beat_reg;

	// a backed-off cycle lets a pending writeback go before the buffer
	wire ccw_cyc_type pick = (i_wb_req && (backed_reg || !lk.head_valid)) ? CYC_WB :
		lk.head_valid ? CYC_BUF : i_io_req ? CYC_IOW : i_rd_req ? CYC_RD : CYC_NONE;
	wire logic start = (state_reg == SEQ_IDLE) && i_bus_backoff_n && (pick != CYC_NONE);
	wire logic running = (state_reg == SEQ_RUN) && i_bus_backoff_n;
	wire logic ken_n_eff = first_reg ? i_cache_enable_in_n : ken_n_reg;
	// linefill only when enable is sampled low with the first ready or next-address strobe
	wire logic fill_now = (kind_reg == CYC_RD) && i_rd_cacheable && !i_rd_io && !ken_n_eff;
	wire logic [1:0] last_beat = (kind_reg == CYC_WB || fill_now) ? `CCW_FILL_LAST : 2'h0;
	wire logic sample_ev = first_reg && (!i_burst_ready_n || !i_next_address_req_n);

	assign o_done = running && !i_burst_ready_n && (beat_reg == last_beat);
	assign o_done_kind = kind_reg;
	// policy input taken with the first ready or next-address strobe
	assign o_done_wp = first_reg ? i_write_policy_select : wp_reg;
	assign o_done_fill = fill_now;
	assign lk.pop = o_done && (kind_reg == CYC_BUF);
	assign o_bus_req = (state_reg == SEQ_RUN);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= SEQ_IDLE;
			kind_reg <= CYC_NONE;
			first_reg <= 1'h0;
			wp_reg <= 1'h0;
			ken_n_reg <= 1'h1;
			backed_reg <= 1'h0;
			beat_reg <= 2'h0;
			o_bus_addr <= 32'h0;
			o_bus_data <= 64'h0;
			o_bus_write <= 1'h0;
			o_bus_io <= 1'h0;
			o_bus_pwt <= 1'h0;
		end else if (start) begin
			state_reg <= SEQ_RUN;
			kind_reg <= pick;
			first_reg <= 1'h1;
			beat_reg <= 2'h0;
			backed_reg <= backed_reg && (pick != CYC_WB);
			o_bus_addr <= (pick == CYC_WB) ? i_wb_addr : (pick == CYC_BUF) ? lk.head.addr :
				(pick == CYC_IOW) ? i_io_addr : i_rd_addr;
			o_bus_data <= (pick == CYC_BUF) ? lk.head.data : i_io_data;
			o_bus_write <= (pick != CYC_RD);
			o_bus_io <= (pick == CYC_IOW) || ((pick == CYC_RD) && i_rd_io);
			o_bus_pwt <= ((pick == CYC_BUF) && lk.head.page_write_through) || ((pick == CYC_RD) && i_rd_pwt);
		end else if (state_reg == SEQ_RUN) begin
			if (!i_bus_backoff_n) begin
				state_reg <= SEQ_IDLE;
				backed_reg <= 1'h1;
			end else begin
				if (sample_ev) begin
					first_reg <= 1'h0;
					wp_reg <= i_write_policy_select;
					ken_n_reg <= i_cache_enable_in_n;
				end
				if (o_done)
					state_reg <= SEQ_IDLE;
				else if (!i_burst_ready_n)
					beat_reg <= beat_reg + 2'h1;
			end
		end
	end

	// reads and i/o writes start only behind an empty buffer
	drain_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		start && (pick == CYC_RD || pick == CYC_IOW) |-> !lk.head_valid)
		else $error("read or io cycle overtook posted writes");
	fill_seen_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		o_done && fill_now);
endmodule

// *** design/ccw_cfg.svh ***
// sizing and timing constants for the coherence and write buffer logic
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH
`define CCW_LINES 8
`define CCW_IDX_W 3
`define CCW_IDX_LSB 5
`define CCW_TAG_LSB 8
`define CCW_TAG_W 24
`define CCW_DATA_W 64
`define CCW_BUF_DEPTH 4
`define CCW_PTR_W 2
`define CCW_CNT_W 3
`define CCW_CAP_BASE 3'h2
`define CCW_CAP_ENH 3'h4
`define CCW_FILL_LAST 2'h3
`define CCW_HIT_N_RST 1'h1
`endif

// *** design/ccw_coherence.sv ***
// data and code cache coherence state with posted write ordering and snoop port
// How it works
// - write hit on Modified line updates cache only, stays Modified, no bus cycle
// - write hit on Exclusive line updates cache, no bus cycle, becomes Modified
// - write hit on Shared line updates cache and runs a write-through cycle
// - Shared write with through-attribute low: policy input picks Exclusive or Shared
// - Shared write with through-attribute high stays Shared, policy input ignored
// - Shared-to-Exclusive state change waits for the last ready of the bus write
// - after going Exclusive new writes make no bus cycles; older ones still may
// - write miss runs a write-through cycle, line stays Invalid, no allocation
// - writes to Exclusive or Modified lines wait while external-write-empty is inactive
// - such writes also wait while any write is buffered or running on bus
// - snoops check both caches; any hit drives hit, modified hit also hit-modified
// - snoop on Modified line schedules writeback, then Shared or Invalid by request
// - snoop on Exclusive or Shared line: hit low, no bus cycle, Shared or Invalid
// - snoop miss leaves hit high and state Invalid
// - code lines only Shared or Invalid; hits internal, misses to bus, maybe fill
// - code cache snoops processor writes, invalidates on hit, never written
// - base mode has two 64-bit write buffers, both fillable in one clock
// - buffered writes leave in order, drained before later cycles except on backoff
// - miss reads never pass buffered writes; buffer drained before an i/o read
// - enhanced mode has four shared buffers drained in FIFO order when bus free
// - only memory writes are posted; i/o writes bypass; program order kept
// - cacheable miss fills if enable low at first ready or next-address strobe; Exclusive or Shared
// - a locked access leaves the accessed data line Invalid
`timescale 1ns/10ps
module ccw_coherence (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enhanced,
	input wire logic i_locked,
	input wire logic i_u_wr_valid,
	input wire logic [31:0] i_u_wr_addr,
	input wire logic [63:0] i_u_wr_data,
	input wire logic i_u_wr_pwt,
	input wire logic i_u_wr_io,
	output logic o_u_wr_ready,
	input wire logic i_v_wr_valid,
	input wire logic [31:0] i_v_wr_addr,
	input wire logic [63:0] i_v_wr_data,
	input wire logic i_v_wr_pwt,
	input wire logic i_v_wr_io,
	output logic o_v_wr_ready,
	input wire logic i_rd_valid,
	input wire logic [31:0] i_rd_addr,
	input wire logic i_rd_code,
	input wire logic i_rd_cacheable,
	input wire logic i_rd_pwt,
	input wire logic i_rd_io,
	output logic o_rd_done,
	input wire logic i_snp_valid,
	input wire logic [31:0] i_snp_addr,
	input wire logic i_snoop_invalidate_req,
	output logic o_snoop_hit_n,
	output logic o_snoop_hit_modified_out_n,
	output logic o_snp_done,
	output logic o_wb_sched,
	input wire logic i_external_write_empty_n,
	input wire logic i_burst_ready_n,
	input wire logic i_next_address_req_n,
	input wire logic i_write_policy_select,
	input wire logic i_cache_enable_in_n,
	input wire logic i_bus_backoff_n,
	output logic o_bus_req,
	output logic [31:0] o_bus_addr,
	output logic [63:0] o_bus_data,
	output logic o_bus_write,
	output logic o_bus_io,
	output logic o_bus_pwt
);
	import ccw_pkg::*;

	// state arrays: 2-bit state per data line, valid bit per code line
	ccw_mesi_type dc_st_reg [`CCW_LINES];
	ccw_mesi_type dc_st_next [`CCW_LINES];
	logic [`CCW_TAG_W-1:0] dc_tag_reg [`CCW_LINES];
	logic [`CCW_TAG_W-1:0] dc_tag_next [`CCW_LINES];
	logic cc_v_reg [`CCW_LINES];
	logic cc_v_next [`CCW_LINES];
	logic [`CCW_TAG_W-1:0] cc_tag_reg [`CCW_LINES];
	logic [`CCW_TAG_W-1:0] cc_tag_next [`CCW_LINES];
	logic wb_pend_reg;
	logic [31:0] wb_addr_reg;
	logic io_req_reg;
	logic [31:0] io_addr_reg;
	logic [63:0] io_data_reg;
	logic seq_done;
	ccw_cyc_type seq_kind;
	logic seq_wp;
	logic seq_fill;
	logic rd_req;

	function automatic logic [`CCW_IDX_W-1:0] idx_of(input logic [31:0] a);
		return a[`CCW_IDX_LSB +: `CCW_IDX_W];
	endfunction

	function automatic logic [`CCW_TAG_W-1:0] tag_of(input logic [31:0] a);
		return a[31:`CCW_TAG_LSB];
	endfunction

	function automatic ccw_mesi_type dc_look(input logic [31:0] a);
		return (dc_tag_reg[idx_of(a)] == tag_of(a)) ? dc_st_reg[idx_of(a)] : MESI_INV;
	endfunction

	function automatic logic cc_look(input logic [31:0] a);
		return cc_v_reg[idx_of(a)] && (cc_tag_reg[idx_of(a)] == tag_of(a));
	endfunction

	ccw_link_if lk ();

	ccw_wbuf u_wbuf (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.lk(lk.fifo)
	);

	ccw_bus_seq u_seq (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.lk(lk.seq),
		.i_wb_req(wb_pend_reg),
		.i_wb_addr(wb_addr_reg),
		.i_io_req(io_req_reg),
		.i_io_addr(io_addr_reg),
		.i_io_data(io_data_reg),
		.i_rd_req(rd_req),
		.i_rd_addr(i_rd_addr),
		.i_rd_cacheable(i_rd_cacheable),
		.i_rd_pwt(i_rd_pwt),
		.i_rd_io(i_rd_io),
		.i_burst_ready_n(i_burst_ready_n),
		.i_next_address_req_n(i_next_address_req_n),
		.i_write_policy_select(i_write_policy_select),
		.i_cache_enable_in_n(i_cache_enable_in_n),
		.i_bus_backoff_n(i_bus_backoff_n),
		.o_bus_req(o_bus_req),
		.o_bus_addr(o_bus_addr),
		.o_bus_data(o_bus_data),
		.o_bus_write(o_bus_write),
		.o_bus_io(o_bus_io),
		.o_bus_pwt(o_bus_pwt),
		.o_done(seq_done),
		.o_done_kind(seq_kind),
		.o_done_wp(seq_wp),
		.o_done_fill(seq_fill)
	);

	wire ccw_mesi_type u_st = dc_look(i_u_wr_addr);
	wire ccw_mesi_type v_st = dc_look(i_v_wr_addr);
	wire ccw_mesi_type snp_st = dc_look(i_snp_addr);
	wire ccw_mesi_type head_st = dc_look(lk.head.addr);
	// unlocked non-i/o writes to Exclusive and Modified lines are written in place, never posted
	wire logic u_em = (u_st == MESI_EXC || u_st == MESI_MOD) && !i_locked && !i_u_wr_io;
	wire logic v_em = (v_st == MESI_EXC || v_st == MESI_MOD) && !i_locked && !i_v_wr_io;
	// in-place writes need an empty external path and a quiet bus
	wire logic quiet = !i_external_write_empty_n && (lk.count == 3'h0) && !io_req_reg &&
		!(o_bus_req && o_bus_write);
	wire logic io_free = (lk.count == 3'h0) && !io_req_reg && !o_bus_req;
	wire logic [`CCW_CNT_W-1:0] space = lk.cap - lk.count;
	wire logic u_ok = i_u_wr_io ? io_free : u_em ? quiet : (space != 3'h0);
	wire logic u_acc = i_u_wr_valid && u_ok;
	// Shared hits and misses post a write-through entry
	wire logic u_push = u_acc && !i_u_wr_io && !u_em;
	// v waits behind a stalled u or a u i/o write, so writes keep program order
	wire logic v_ok = i_v_wr_io ? (io_free && !i_u_wr_valid) :
		(i_u_wr_valid && i_u_wr_io) ? 1'h0 : v_em ? (quiet && !u_push) :
		(space >= ({2'h0, u_push} + 3'h1));
	wire logic v_acc = i_v_wr_valid && v_ok && (!i_u_wr_valid || u_acc);
	wire logic v_push = v_acc && !i_v_wr_io && !v_em;
	// i/o writes skip the buffer and run directly
	wire logic io_acc = (u_acc && i_u_wr_io) || (v_acc && i_v_wr_io);
	// reads hit internally; i/o, locked and missing reads go to the bus
	wire logic rd_hit = !i_rd_io && !i_locked &&
		(i_rd_code ? cc_look(i_rd_addr) : (dc_look(i_rd_addr) != MESI_INV));
	// a missing read waits until posted and i/o writes are gone
	assign rd_req = i_rd_valid && !rd_hit && (lk.count == 3'h0) && !io_req_reg;
	wire logic rd_done = seq_done && (seq_kind == CYC_RD);
	// upgrade at the last ready, only if policy sampled high
	wire logic upg_ok = lk.pop && lk.head.upgrade && seq_wp && (head_st == MESI_SHR);
	wire logic snp_hit = (snp_st != MESI_INV) || cc_look(i_snp_addr);
	wire logic snp_snoop_hit_modified_out = (snp_st == MESI_MOD);

	assign o_u_wr_ready = u_ok;
	assign o_v_wr_ready = v_ok && (!i_u_wr_valid || u_acc);
	assign o_rd_done = (i_rd_valid && rd_hit) || rd_done;
	// two entries in base mode, four in enhanced mode
	assign lk.cap = i_enhanced ? `CCW_CAP_ENH : `CCW_CAP_BASE;
	assign lk.push0 = u_push;
	assign lk.push1 = v_push;
	// an upgrade is only armed when the through-attribute is low
	assign lk.ent0 = '{addr: i_u_wr_addr, data: i_u_wr_data, page_write_through: i_u_wr_pwt,
		upgrade: (u_st == MESI_SHR) && !i_u_wr_pwt && !i_locked};
	assign lk.ent1 = '{addr: i_v_wr_addr, data: i_v_wr_data, page_write_through: i_v_wr_pwt,
		upgrade: (v_st == MESI_SHR) && !i_v_wr_pwt && !i_locked};

	// later updates override earlier ones; a snoop has the final say on a line
	always_comb begin
		dc_st_next = dc_st_reg;
		dc_tag_next = dc_tag_reg;
		cc_v_next = cc_v_reg;
		cc_tag_next = cc_tag_reg;
		// write in place: Exclusive goes Modified, Modified stays
		if (u_acc && u_em)
			dc_st_next[idx_of(i_u_wr_addr)] = MESI_MOD;
		if (v_acc && v_em)
			dc_st_next[idx_of(i_v_wr_addr)] = MESI_MOD;
		// processor writes invalidate matching code lines
		if (u_acc && !i_u_wr_io && cc_look(i_u_wr_addr))
			cc_v_next[idx_of(i_u_wr_addr)] = 1'h0;
		if (v_acc && !i_v_wr_io && cc_look(i_v_wr_addr))
			cc_v_next[idx_of(i_v_wr_addr)] = 1'h0;
		// locked writes leave the data line Invalid
		if (u_acc && i_locked && !i_u_wr_io && (u_st != MESI_INV))
			dc_st_next[idx_of(i_u_wr_addr)] = MESI_INV;
		if (v_acc && i_locked && !i_v_wr_io && (v_st != MESI_INV))
			dc_st_next[idx_of(i_v_wr_addr)] = MESI_INV;
		if (upg_ok)
			dc_st_next[idx_of(lk.head.addr)] = MESI_EXC;
		if (rd_done && seq_fill) begin
			if (i_rd_code) begin
				cc_v_next[idx_of(i_rd_addr)] = 1'h1;
				cc_tag_next[idx_of(i_rd_addr)] = tag_of(i_rd_addr);
			end else begin
				dc_tag_next[idx_of(i_rd_addr)] = tag_of(i_rd_addr);
				dc_st_next[idx_of(i_rd_addr)] = (seq_wp && !i_rd_pwt) ? MESI_EXC : MESI_SHR;
			end
		end
		// locked reads leave the data line Invalid
		if (rd_done && i_locked && !i_rd_code)
			dc_st_next[idx_of(i_rd_addr)] = MESI_INV;
		// snoop hit goes Shared, or Invalid on request
		if (i_snp_valid && (snp_st != MESI_INV))
			dc_st_next[idx_of(i_snp_addr)] = i_snoop_invalidate_req ? MESI_INV : MESI_SHR;
		if (i_snp_valid && i_snoop_invalidate_req && cc_look(i_snp_addr))
			cc_v_next[idx_of(i_snp_addr)] = 1'h0;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < `CCW_LINES; i++) begin
				dc_st_reg[i] <= MESI_INV;
				dc_tag_reg[i] <= 24'h0;
				cc_v_reg[i] <= 1'h0;
				cc_tag_reg[i] <= 24'h0;
			end
		end else begin
			dc_st_reg <= dc_st_next;
			dc_tag_reg <= dc_tag_next;
			cc_v_reg <= cc_v_next;
			cc_tag_reg <= cc_tag_next;
		end
	end

	// snoop answer is registered and stands until the next snoop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_snoop_hit_n <= `CCW_HIT_N_RST;
			o_snoop_hit_modified_out_n <= `CCW_HIT_N_RST;
			o_snp_done <= 1'h0;
			o_wb_sched <= 1'h0;
		end else begin
			o_snp_done <= i_snp_valid;
			o_wb_sched <= i_snp_valid && snp_snoop_hit_modified_out;
			if (i_snp_valid) begin
				o_snoop_hit_n <= !snp_hit;
				o_snoop_hit_modified_out_n <= !snp_snoop_hit_modified_out;
			end
		end
	end

	// writeback pending; a new modified hit wins over the completion
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wb_pend_reg <= 1'h0;
			wb_addr_reg <= 32'h0;
		end else if (i_snp_valid && snp_snoop_hit_modified_out) begin
			wb_pend_reg <= 1'h1;
			wb_addr_reg <= {i_snp_addr[31:`CCW_IDX_LSB], 5'h0};
		end else if (seq_done && (seq_kind == CYC_WB)) begin
			wb_pend_reg <= 1'h0;
		end
	end

	// one direct i/o write held until the sequencer completes it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			io_req_reg <= 1'h0;
			io_addr_reg <= 32'h0;
			io_data_reg <= 64'h0;
		end else if (io_acc) begin
			io_req_reg <= 1'h1;
			io_addr_reg <= i_u_wr_io ? i_u_wr_addr : i_v_wr_addr;
			io_data_reg <= i_u_wr_io ? i_u_wr_data : i_v_wr_data;
		end else if (seq_done && (seq_kind == CYC_IOW)) begin
			io_req_reg <= 1'h0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	mod_write_stays_a: assert property (u_acc && u_em && (u_st == MESI_MOD) && !i_snp_valid
		|-> !lk.push0 ##1 dc_st_reg[$past(idx_of(i_u_wr_addr))] == MESI_MOD)
		else $error("modified write left its state or posted a cycle");
	excl_to_mod_a: assert property (u_acc && u_em && (u_st == MESI_EXC) && !i_snp_valid
		|=> dc_st_reg[$past(idx_of(i_u_wr_addr))] == MESI_MOD)
		else $error("exclusive write did not go modified");
	shared_posts_a: assert property (u_acc && !i_u_wr_io && (u_st == MESI_SHR)
		|-> lk.push0 && lk.ent0.upgrade == (!i_u_wr_pwt && !i_locked))
		else $error("shared write not posted as write-through");
	miss_no_alloc_a: assert property (u_acc && !i_u_wr_io && (u_st == MESI_INV)
		|-> lk.push0 && !lk.ent0.upgrade) else $error("write miss not written through");
	em_quiet_a: assert property ((u_acc && u_em) || (v_acc && v_em) |->
		!i_external_write_empty_n && lk.count == 3'h0 && !(o_bus_req && o_bus_write))
		else $error("in-place write while writes pending");
	io_no_post_a: assert property (io_acc |-> !lk.push0 && !lk.push1 ##1 io_req_reg)
		else $error("io write was posted");
	snoop_snoop_hit_modified_out_a: assert property (i_snp_valid && snp_snoop_hit_modified_out
		|=> !o_snoop_hit_n && !o_snoop_hit_modified_out_n && o_wb_sched && wb_pend_reg)
		else $error("modified snoop hit not reported");
	snoop_miss_a: assert property (i_snp_valid && !snp_hit
		|=> o_snoop_hit_n && o_snoop_hit_modified_out_n && !o_wb_sched)
		else $error("snoop miss reported as hit");
	snoop_inv_a: assert property (i_snp_valid && i_snoop_invalidate_req && (snp_st != MESI_INV)
		|=> dc_st_reg[$past(idx_of(i_snp_addr))] == MESI_INV)
		else $error("invalidating snoop left line valid");
	read_order_a: assert property ($rose(o_bus_req) && !o_bus_write |-> $past(lk.count) == 3'h0)
		else $error("read overtook posted writes");

	upgrade_seen_c: cover property (upg_ok);
	dual_push_c: cover property (lk.push0 && lk.push1);
	snoop_hit_modified_out_seen_c: cover property (i_snp_valid && snp_snoop_hit_modified_out);
endmodule

// *** design/ccw_link_if.sv ***
// link between the coherence core, the posted write buffer and the bus sequencer
`timescale 1ns/10ps
interface ccw_link_if;
	import ccw_pkg::*;
	logic push0;
	logic push1;
	ccw_went_type ent0;
	ccw_went_type ent1;
	logic [`CCW_CNT_W-1:0] cap;
	logic [`CCW_CNT_W-1:0] count;
	logic head_valid;
	ccw_went_type head;
	logic pop;
	modport core (output push0, push1, ent0, ent1, cap, input count, head_valid, head, pop);
	modport fifo (input push0, push1, ent0, ent1, cap, pop, output count, head_valid, head);
	modport seq (input head_valid, head, output pop);
endinterface

// *** design/ccw_pkg.sv ***
// types shared by the coherence logic, its write buffer and its bus sequencer
package ccw_pkg;
`include "ccw_cfg.svh"
	typedef enum logic [1:0] {MESI_INV, MESI_SHR, MESI_EXC, MESI_MOD} ccw_mesi_type;
	typedef enum logic [2:0] {CYC_NONE, CYC_WB, CYC_BUF, CYC_IOW, CYC_RD} ccw_cyc_type;
	typedef enum logic {SEQ_IDLE, SEQ_RUN} ccw_seq_type;
	typedef struct packed {
		logic [31:0] addr;
		logic [`CCW_DATA_W-1:0] data;
		logic page_write_through;
		logic upgrade;
	} ccw_went_type;
endpackage

// *** design/ccw_wbuf.sv ***
// posted write buffer: up to two pushes per clock, drained in push order
`timescale 1ns/10ps
module ccw_wbuf (
	input wire logic i_clk,
	input wire logic i_rst_n,
	ccw_link_if.fifo lk
);
	import ccw_pkg::*;

	ccw_went_type mem_reg [`CCW_BUF_DEPTH];
	logic [`CCW_PTR_W-1:0] wr_ptr_reg;
	logic [`CCW_PTR_W-1:0] rd_ptr_reg;
	logic [`CCW_CNT_W-1:0] count_reg;
	wire logic [`CCW_CNT_W-1:0] n_push = {2'h0, lk.push0} + {2'h0, lk.push1};
	wire logic [`CCW_PTR_W-1:0] slot1 = lk.push0 ? wr_ptr_reg + 2'h1 : wr_ptr_reg;

	// same-clock fill, u entry ahead of v
	always_ff @(posedge i_clk) begin
		if (lk.push0)
			mem_reg[wr_ptr_reg] <= lk.ent0;
		if (lk.push1)
			mem_reg[slot1] <= lk.ent1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg <= 3'h0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + n_push[`CCW_PTR_W-1:0];
			rd_ptr_reg <= rd_ptr_reg + {1'h0, lk.pop};
			count_reg <= count_reg + n_push - {2'h0, lk.pop};
		end
	end

	assign lk.count = count_reg;
	assign lk.head_valid = (count_reg != 3'h0);
	assign lk.head = mem_reg[rd_ptr_reg];

	buf_capacity_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		count_reg <= lk.cap) else $error("write buffer above its capacity");
endmodule

// *** sim/ccw_bus_model.sv ***
// behavioural system bus controller facing the coherence block
`timescale 1ns/10ps
module ccw_bus_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_req,
	input wire logic i_pol,
	input wire logic i_ken_n,
	input wire logic [1:0] i_slow,
	input wire logic i_io,
	output logic o_burst_ready_n,
	output logic o_next_address_req_n,
	output logic o_write_policy_select,
	output logic o_cache_enable_in_n,
	output logic o_bus_backoff_n
);
	logic [1:0] wait_reg;
	wire logic [1:0] min_wait;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			wait_reg <= 2'h0;
		else if (!i_bus_req)
			wait_reg <= 2'h0;
		else if (wait_reg != 2'h3)
			wait_reg <= wait_reg + 2'h1;
	end
	// an output cycle gets three clocks for changed interrupt inputs to settle
	assign min_wait = i_io ? 2'h3 : i_slow;
	// ready beats held low until the block drops its request
	assign o_burst_ready_n = !(i_bus_req && wait_reg >= min_wait);
	assign o_next_address_req_n = 1'h1;
	assign o_bus_backoff_n = 1'h1;
	// policy and enable as sampled with ready
	// outside a cycle the sampled inputs show the opposite level
	assign o_write_policy_select = i_bus_req ? i_pol : !i_pol;
	assign o_cache_enable_in_n = i_bus_req ? i_ken_n : !i_ken_n;
endmodule

// *** sim/tb_top.sv ***
// self-checking testbench for the coherence block
`timescale 1ns/10ps
module tb_top;
	logic i_clk=0, i_rst_n=0, i_enhanced=0, i_locked=0, i_u_wr_valid=0, i_u_wr_io=0, page_write_through=0;
	logic i_v_wr_valid=0, i_v_wr_io=0, i_rd_valid=0, i_rd_code=0, i_rd_cacheable=1, i_rd_io=0;
	logic i_snp_valid=0, i_snoop_invalidate_req=0, i_external_write_empty_n=0, pol=0, ken_n=1;
	logic [31:0] i_u_wr_addr=0, i_v_wr_addr=0, i_rd_addr=0, i_snp_addr=0;
	logic [1:0] slow=0;
	wire logic [63:0] i_u_wr_data = {32'h0, i_u_wr_addr};
	wire logic [63:0] i_v_wr_data = {32'h0, i_v_wr_addr};
	logic o_u_wr_ready, o_v_wr_ready, o_rd_done, o_snoop_hit_n, o_snoop_hit_modified_out_n;
	logic o_snp_done, o_wb_sched, o_bus_req, o_bus_write, o_bus_io, o_bus_pwt, i_burst_ready_n;
	logic i_next_address_req_n, i_write_policy_select, i_cache_enable_in_n, i_bus_backoff_n;
	logic [31:0] o_bus_addr;
	logic [63:0] o_bus_data;
	logic req_d=0;
	logic [31:0] seen[$];
	logic [66:0] attr[$];
	int n_mismatch=0, total_checks=0, n_cyc=0, c;
	ccw_coherence dut_u (.i_clk, .i_rst_n, .i_enhanced, .i_locked, .i_u_wr_valid, .i_u_wr_addr,
		.i_u_wr_data, .i_u_wr_pwt(page_write_through), .i_u_wr_io, .o_u_wr_ready, .i_v_wr_valid, .i_v_wr_addr,
		.i_v_wr_data, .i_v_wr_pwt(page_write_through), .i_v_wr_io, .o_v_wr_ready, .i_rd_valid, .i_rd_addr,
		.i_rd_code, .i_rd_cacheable, .i_rd_pwt(page_write_through), .i_rd_io, .o_rd_done, .i_snp_valid,
		.i_snp_addr, .i_snoop_invalidate_req, .o_snoop_hit_n, .o_snoop_hit_modified_out_n,
		.o_snp_done, .o_wb_sched, .i_external_write_empty_n, .i_burst_ready_n,
		.i_next_address_req_n, .i_write_policy_select, .i_cache_enable_in_n, .i_bus_backoff_n,
		.o_bus_req, .o_bus_addr, .o_bus_data, .o_bus_write, .o_bus_io, .o_bus_pwt);
	ccw_bus_model bus_u (.i_clk, .i_rst_n, .i_bus_req(o_bus_req), .i_pol(pol), .i_ken_n(ken_n),
		.i_slow(slow), .i_io(o_bus_io), .o_burst_ready_n(i_burst_ready_n),
		.o_next_address_req_n(i_next_address_req_n), .o_write_policy_select(i_write_policy_select),
		.o_cache_enable_in_n(i_cache_enable_in_n), .o_bus_backoff_n(i_bus_backoff_n));
	initial begin
		forever #20 i_clk = ~i_clk;
	end
	// every started bus cycle is logged by address
	always @(posedge i_clk) begin
		req_d <= o_bus_req;
		if (o_bus_req && !req_d) begin
			n_cyc++;
			seen.push_back(o_bus_addr);
			attr.push_back({o_bus_write, o_bus_io, o_bus_pwt, o_bus_data});
		end
	end
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// waits at falling edges for write ready (w=0) or read done (w=1), bounded
	task wt(input int w);
		int k;
		k = 0;
		@(negedge i_clk);
		while ((w == 0 ? o_u_wr_ready : o_rd_done) !== 1'b1 && k < 200) begin
			k++;
			@(negedge i_clk);
		end
		if (k >= 200) begin
			n_mismatch++;
			stop_test;
		end
		@(posedge i_clk);
	endtask
	task idle;
		int k, j;
		k = 0;
		for (j = 0; j < 300 && k < 6; j++) begin
			@(posedge i_clk);
			#1 k = o_bus_req ? 0 : k + 1;
		end
		if (k < 6) begin
			n_mismatch++;
			stop_test;
		end
	endtask
	task wr(input logic [31:0] a, input logic p);
		@(posedge i_clk);
		#1 i_u_wr_valid = 1; i_u_wr_addr = a; page_write_through = p;
		wt(0);
		#1 i_u_wr_valid = 0;
		idle;
	endtask
	task snp(input logic [31:0] a, input logic snoop_invalidate_req, input logic eh, input logic ehm);
		@(posedge i_clk);
		#1 i_snp_valid = 1; i_snp_addr = a; i_snoop_invalidate_req = snoop_invalidate_req;
		@(posedge i_clk);
		#1 i_snp_valid = 0;
		chk(o_snp_done === 1'b1 && o_snoop_hit_n === eh, "snoop hit");
		chk(o_snoop_hit_modified_out_n === ehm && o_wb_sched === !ehm, "snoop modified");
	endtask
	task rd(input logic [31:0] a);
		@(posedge i_clk);
		#1 i_rd_valid = 1;
		i_rd_addr = a;
		wt(1);
		#1 i_rd_valid = 0;
		idle;
	endtask
	task t_miss;
		c = n_cyc;
		wr(32'h1000, 0);
		chk(n_cyc == c + 1 && seen[$] === 32'h1000, "miss write-through");
		chk(attr[$] === {3'h4, 64'h1000}, "miss cycle fields");
		snp(32'h1000, 0, 1, 1);
		$display("test miss done");
	endtask
	task t_pair;
		@(posedge i_clk);
		#1 {i_u_wr_valid, i_v_wr_valid, i_u_wr_addr, i_v_wr_addr} = {2'h3, 32'h2020, 32'h3040};
		@(negedge i_clk);
		chk(o_u_wr_ready === 1'b1 && o_v_wr_ready === 1'b1, "dual fill");
		@(posedge i_clk);
		#1 {i_u_wr_valid, i_v_wr_valid} = 2'h0;
		idle;
		chk(seen[$-1] === 32'h2020 && seen[$] === 32'h3040, "write order");
		chk(attr[$-1][31:0] === 32'h2020 && attr[$][31:0] === 32'h3040, "pair data");
		$display("test pair done");
	endtask
	task t_code;
		ken_n = 0;
		i_rd_code = 1;
		c = n_cyc;
		rd(32'h4000);
		rd(32'h4000);
		chk(n_cyc == c + 1, "code hit internal");
		i_rd_code = 0;
		ken_n = 1;
		snp(32'h4000, 0, 0, 1);
		wr(32'h4000, 0);
		snp(32'h4000, 0, 1, 1);
		$display("test code done");
	endtask
	task t_io;
		c = n_cyc;
		i_u_wr_io = 1;
		wr(32'h0040, 0);
		i_u_wr_io = 0;
		chk(n_cyc == c + 1 && seen[$] === 32'h0040, "io write direct");
		chk(attr[$][65] === 1'b1, "io cycle marked");
		$display("test io done");
	endtask
	task t_mesi;
		ken_n = 0;
		rd(32'h1000);
		ken_n = 1;
		pol = 1;
		chk(seen[$] === 32'h1000 && attr[$][66] === 1'b0, "read miss cycle");
		snp(32'h1000, 0, 0, 1);
		c = n_cyc;
		wr(32'h1000, 1);
		chk(n_cyc == c + 1 && attr[$][64] === 1'b1, "through page write");
		wr(32'h1000, 0);
		chk(n_cyc == c + 2, "shared write upgrade");
		wr(32'h1000, 0);
		chk(n_cyc == c + 2, "exclusive write silent");
		i_external_write_empty_n = 1;
		@(posedge i_clk);
		#1 i_u_wr_valid = 1;
		repeat (3) @(negedge i_clk);
		chk(o_u_wr_ready === 1'b0, "held off");
		@(posedge i_clk);
		#1 i_external_write_empty_n = 0;
		wt(0);
		#1 i_u_wr_valid = 0;
		idle;
		chk(n_cyc == c + 2, "modified write silent");
		slow = 2;
		snp(32'h1000, 0, 0, 0);
		idle;
		chk(n_cyc == c + 3 && seen[$][4:0] === 5'h0, "writeback");
		snp(32'h1000, 1, 0, 1);
		snp(32'h1000, 1, 1, 1);
		$display("test mesi done");
	endtask
	initial begin
		repeat (10) @(posedge i_clk);
		#1 i_rst_n = 1;
		t_miss;
		t_pair;
		t_code;
		t_io;
		t_mesi;
		stop_test;
	end
endmodule
